/* lcd_bridge_pkg.sv */
package lcd_bridge_pkg;
  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_COMMAND_BUSY = 12'h000;
  localparam logic [11:0] OFS_DATA_PORT = 12'h004;
  localparam logic [11:0] OFS_CAPTURED_READ = 12'h008;
  localparam logic [11:0] OFS_RAW_DONE_FLAG = 12'h00c;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
  localparam logic [11:0] OFS_MASKED_STATUS = 12'h014;
  localparam logic [11:0] OFS_PIN_CONTROL = 12'h04c;
  // ------------------------------------------------------------
  // pin control fields
  // ------------------------------------------------------------
  localparam int PIN_CS_BIT = 0;
  localparam int PIN_WR_BIT = 1;
  localparam int PIN_RESET_BIT = 3;
  localparam int PIN_RS_BIT = 4;
  localparam int PIN_RD_BIT = 5;
  localparam int PIN_BL_BIT = 6;
  localparam logic [31:0] PIN_CONTROL_WMASK = 32'h0000_007b;
  // strobes and chip select idle high, panel out of reset, lamp off
  localparam logic [31:0] PIN_CONTROL_RESET = 32'h0000_002b;
  localparam int DONE_FLAG_BIT = 0;
  localparam int MASK_BIT = 0;
  // ------------------------------------------------------------
  // panel bus timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int PHASE_NS = 60;
  localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_state_t;
endpackage : lcd_bridge_pkg

/* lcd_bus_engine.sv */
`timescale 1ns/1ns
module lcd_bus_engine #(
  parameter int PHASE_CYC = lcd_bridge_pkg::PHASE_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  lcd_cycle_if.eng cyc,
  input wire logic idle_cs,
  input wire logic idle_wr,
  input wire logic idle_rd,
  input wire logic idle_rs,
  input wire logic [7:0] panel_data_in,
  output logic pin_cs,
  output logic pin_wr,
  output logic pin_rd,
  output logic pin_rs,
  output logic [7:0] pin_data_out,
  output logic pin_data_oe
);
  import lcd_bridge_pkg::*;

  // cycles from the taken start request to the done pulse
  localparam int CYC_LEN = 3 * PHASE_CYC + 1;

  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  if (PHASE_CYC < 1 || PHASE_CYC > 15) begin : g_chk
    $error("PHASE_CYC out of range");
  end

  typedef struct packed {
    eng_state_t st;
    logic [3:0] cnt;
    logic rd;
    logic rs;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic done;
    logic cs;
    logic wr;
    logic rdp;
    logic rsp;
    logic oe;
  } eng_t;

  eng_t s_r, s_nxt;
  logic act;

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    act = 1'b0;
    case (s_r.st)
      E_IDLE: begin
        if (cyc.start) begin
          s_nxt.st = E_SETUP;
          s_nxt.cnt = 4'(PHASE_CYC - 1);
          s_nxt.rd = cyc.rd;
          s_nxt.rs = cyc.rs;
          s_nxt.wbyte = cyc.wbyte;
        end
      end
      E_SETUP: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.st = E_STROBE;
          s_nxt.cnt = 4'(PHASE_CYC - 1);
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      E_STROBE: begin
        if (s_r.cnt == 4'h0) begin
          // sample at the end of the strobe, while data is still held
          if (s_r.rd) begin
            s_nxt.rbyte = panel_data_in;
          end
          s_nxt.st = E_HOLD;
          s_nxt.cnt = 4'(PHASE_CYC - 1);
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      E_HOLD: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.st = E_IDLE;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      default: s_nxt.st = E_IDLE;
    endcase
    // pins follow the pin control register outside a cycle
    act = (s_nxt.st != E_IDLE);
    s_nxt.cs = act ? 1'b0 : idle_cs;
    s_nxt.rsp = act ? s_nxt.rs : idle_rs;
    s_nxt.wr = act ? !(s_nxt.st == E_STROBE && !s_nxt.rd) : idle_wr;
    s_nxt.rdp = act ? !(s_nxt.st == E_STROBE && s_nxt.rd) : idle_rd;
    s_nxt.oe = act && !s_nxt.rd;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_r <= '{st: E_IDLE, cnt: 4'h0, rd: 1'b0, rs: 1'b0, wbyte: 8'h00,
               rbyte: 8'h00, done: 1'b0, cs: 1'b1, wr: 1'b1, rdp: 1'b1,
               rsp: 1'b0, oe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cyc.busy = (s_r.st != E_IDLE);
  assign cyc.done = s_r.done;
  assign cyc.rbyte = s_r.rbyte;
  assign pin_cs = s_r.cs;
  assign pin_wr = s_r.wr;
  assign pin_rd = s_r.rdp;
  assign pin_rs = s_r.rsp;
  assign pin_data_out = s_r.wbyte;
  assign pin_data_oe = s_r.oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_cycle_start;
    cyc.start && s_r.st == E_IDLE;
  endsequence

  a_cycle_selects: assert property (
    s_cycle_start |=> !pin_cs)
    else $error("chip select not low after cycle start");
  a_cycle_length: assert property (
    s_cycle_start |-> ##CYC_LEN cyc.done)
    else $error("cycle did not complete in time");
  a_write_strobe_width: assert property (
    ($fell(pin_wr) && s_r.st == E_STROBE) |-> (!pin_wr && !pin_cs)[*3])
    else $error("write strobe too short");
  a_read_no_drive: assert property (
    (!pin_rd && !pin_cs) |-> !pin_data_oe)
    else $error("data driven during read strobe");
endmodule : lcd_bus_engine

/* lcd_cycle_if.sv */
`timescale 1ns/1ns
interface lcd_cycle_if;
  logic start;
  logic rd;
  logic rs;
  logic [7:0] wbyte;
  logic busy;
  logic done;
  logic [7:0] rbyte;
  modport ctl (output start, rd, rs, wbyte, input busy, done, rbyte);
  modport eng (input start, rd, rs, wbyte, output busy, done, rbyte);
endinterface : lcd_cycle_if

/* lcd_parallel_bus_bridge.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - write to command offset runs a panel command-register write cycle
// - read of command offset runs a panel busy-register read cycle
// - write to data offset runs a panel data-register write cycle
// - read of data offset runs a panel data-register read cycle
// - captured register holds last read byte in low eight bits
// - done flag bit 0 sets when a requested read delivers data
// - writing zero to flag bit 0 clears it until next read
// - mask bit 0 at one lets the done flag raise interrupt
// - masked status bit 0 reads flag AND mask bit 0
// - pin control bits drive backlight and reset, and drive strobes, select and chip select between cycles
// - panel is served over a parallel bus; touch lies elsewhere
module lcd_parallel_bus_bridge (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [lcd_bridge_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ready,
  output logic panel_irq,
  output logic panel_chip_select,
  output logic panel_write_strobe,
  output logic panel_read_strobe,
  output logic panel_register_select,
  output logic panel_reset_line,
  output logic panel_backlight,
  input wire logic [7:0] panel_data_in,
  output logic [7:0] panel_data_out,
  output logic panel_data_oe
);
  import lcd_bridge_pkg::*;

  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic start;
    logic rd;
    logic rs;
    logic [7:0] wbyte;
    logic flag;
    logic mask;
    logic [7:0] capt;
    logic [31:0] misc;
    logic irq;
  } top_t;

  top_t s_r, s_nxt;
  logic take;
  logic port_hit;
  logic accept;
  logic read_done;

  lcd_cycle_if cyc ();

  // ------------------------------------------------------------
  // register port and flag logic
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.start = 1'b0;
    take = reg_sel && !s_r.ready;
    port_hit = (reg_addr == OFS_COMMAND_BUSY) || (reg_addr == OFS_DATA_PORT);
    // panel offsets wait while a cycle is pending, which stalls the cpu
    accept = take && !(port_hit && (s_r.start || cyc.busy));
    read_done = cyc.done && s_r.rd;
    if (accept) begin
      s_nxt.ready = 1'b1;
      s_nxt.rdata = 32'h0000_0000;
      if (port_hit) begin
        s_nxt.start = 1'b1;
        s_nxt.rd = !reg_write;
        s_nxt.rs = (reg_addr == OFS_DATA_PORT);
        s_nxt.wbyte = reg_wdata[7:0];
      end else if (reg_write) begin
        case (reg_addr)
          OFS_RAW_DONE_FLAG: begin
            if (!reg_wdata[DONE_FLAG_BIT]) begin
              s_nxt.flag = 1'b0;
            end
          end
          OFS_IRQ_MASK: s_nxt.mask = reg_wdata[MASK_BIT];
          OFS_PIN_CONTROL: s_nxt.misc = reg_wdata & PIN_CONTROL_WMASK;
          default: s_nxt.misc = s_r.misc;
        endcase
      end else begin
        case (reg_addr)
          OFS_CAPTURED_READ: s_nxt.rdata = {24'h000000, s_r.capt};
          OFS_RAW_DONE_FLAG: s_nxt.rdata = {31'h0, s_r.flag};
          OFS_MASKED_STATUS: s_nxt.rdata = {31'h0, s_r.flag & s_r.mask};
          OFS_PIN_CONTROL: s_nxt.rdata = s_r.misc;
          default: s_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
    // completion is applied last so it wins over a same-cycle clear
    if (read_done) begin
      s_nxt.capt = cyc.rbyte;
      s_nxt.flag = 1'b1;
    end
    s_nxt.irq = s_nxt.flag & s_nxt.mask;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_r <= '{ready: 1'b0, rdata: 32'h0000_0000, start: 1'b0, rd: 1'b0,
               rs: 1'b0, wbyte: 8'h00, flag: 1'b0, mask: 1'b0,
               capt: 8'h00, misc: PIN_CONTROL_RESET, irq: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cyc.start = s_r.start;
  assign cyc.rd = s_r.rd;
  assign cyc.rs = s_r.rs;
  assign cyc.wbyte = s_r.wbyte;
  assign reg_rdata = s_r.rdata;
  assign reg_ready = s_r.ready;
  assign panel_irq = s_r.irq;
  assign panel_reset_line = s_r.misc[PIN_RESET_BIT];
  assign panel_backlight = s_r.misc[PIN_BL_BIT];

  // ------------------------------------------------------------
  // panel bus sequencer
  // ------------------------------------------------------------
  lcd_bus_engine #(.PHASE_CYC(PHASE_CYC)) u_engine (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cyc(cyc.eng),
    .idle_cs(s_r.misc[PIN_CS_BIT]),
    .idle_wr(s_r.misc[PIN_WR_BIT]),
    .idle_rd(s_r.misc[PIN_RD_BIT]),
    .idle_rs(s_r.misc[PIN_RS_BIT]),
    .panel_data_in(panel_data_in),
    .pin_cs(panel_chip_select),
    .pin_wr(panel_write_strobe),
    .pin_rd(panel_read_strobe),
    .pin_rs(panel_register_select),
    .pin_data_out(panel_data_out),
    .pin_data_oe(panel_data_oe)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_cmd_write;
    accept && reg_write && reg_addr == OFS_COMMAND_BUSY;
  endsequence
  sequence s_data_write;
    accept && reg_write && reg_addr == OFS_DATA_PORT;
  endsequence
  sequence s_busy_read;
    accept && !reg_write && reg_addr == OFS_COMMAND_BUSY;
  endsequence
  sequence s_data_read;
    accept && !reg_write && reg_addr == OFS_DATA_PORT;
  endsequence

  a_cmd_write_launch: assert property (
    s_cmd_write |=> s_r.start && !s_r.rd && !s_r.rs
      && s_r.wbyte == $past(reg_wdata[7:0]))
    else $error("command write did not launch a write cycle");
  a_data_write_launch: assert property (
    s_data_write |=> s_r.start && !s_r.rd && s_r.rs
      && s_r.wbyte == $past(reg_wdata[7:0]))
    else $error("data write did not launch a write cycle");
  a_busy_read_launch: assert property (
    s_busy_read |=> s_r.start && s_r.rd && !s_r.rs ##1 cyc.busy)
    else $error("busy read did not launch a read cycle");
  a_data_read_launch: assert property (
    s_data_read |=> s_r.start && s_r.rd && s_r.rs ##1 cyc.busy)
    else $error("data read did not launch a read cycle");
  a_other_reads_zero: assert property (
    (accept && !reg_write && reg_addr != OFS_CAPTURED_READ
      && reg_addr != OFS_RAW_DONE_FLAG && reg_addr != OFS_MASKED_STATUS
      && reg_addr != OFS_PIN_CONTROL) |=> reg_ready && reg_rdata == 32'h0)
    else $error("read of a non-stored offset not zero");
  a_capture_read: assert property (
    (accept && !reg_write && reg_addr == OFS_CAPTURED_READ)
      |=> reg_rdata == {24'h000000, $past(s_r.capt)})
    else $error("captured byte read wrong");
  a_capture_byte: assert property (
    read_done |=> s_r.capt == $past(cyc.rbyte) && s_r.flag)
    else $error("read byte not captured with flag");
  a_flag_read: assert property (
    (accept && !reg_write && reg_addr == OFS_RAW_DONE_FLAG)
      |=> reg_rdata == {31'h0, $past(s_r.flag)})
    else $error("done flag read wrong");
  a_flag_hold_low: assert property (
    (!s_r.flag && !read_done) |=> !s_r.flag)
    else $error("done flag rose without a read");
  a_flag_clear: assert property (
    (accept && reg_write && reg_addr == OFS_RAW_DONE_FLAG
      && !reg_wdata[0] && !read_done) |=> !s_r.flag)
    else $error("done flag not cleared");
  a_flag_keep_high: assert property (
    (s_r.flag && !(accept && reg_write && reg_addr == OFS_RAW_DONE_FLAG
      && !reg_wdata[DONE_FLAG_BIT])) |=> s_r.flag)
    else $error("done flag dropped without a clear");
  a_mask_enables_irq: assert property (
    (accept && reg_write && reg_addr == OFS_IRQ_MASK
      && reg_wdata[MASK_BIT] && s_r.flag) |=> panel_irq)
    else $error("mask set but interrupt low");
  a_mask_blocks_irq: assert property (
    (accept && reg_write && reg_addr == OFS_IRQ_MASK
      && !reg_wdata[MASK_BIT]) |=> !panel_irq)
    else $error("mask cleared but interrupt high");
  a_status_read: assert property (
    (accept && !reg_write && reg_addr == OFS_MASKED_STATUS)
      |=> reg_ready && reg_rdata == {31'h0, $past(s_r.flag & s_r.mask)})
    else $error("masked status read wrong");
  a_irq_gated: assert property (
    panel_irq |-> $past(s_nxt.flag) && s_r.mask && s_r.flag)
    else $error("interrupt without flag and mask");
  a_pin_backlight: assert property (
    (accept && reg_write && reg_addr == OFS_PIN_CONTROL)
      |=> panel_backlight == $past(reg_wdata[6])
      && s_r.misc[31:7] == 25'h0)
    else $error("pin control write not applied");
  a_pins_follow: assert property (
    (!cyc.busy && !cyc.start) |=>
      panel_chip_select == $past(s_r.misc[PIN_CS_BIT])
      && panel_write_strobe == $past(s_r.misc[PIN_WR_BIT])
      && panel_read_strobe == $past(s_r.misc[PIN_RD_BIT])
      && panel_register_select == $past(s_r.misc[PIN_RS_BIT]))
    else $error("idle pins do not follow pin control");
endmodule : lcd_parallel_bus_bridge

/* panel_ctrl_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// colour panel controller model
// ------------------------------------------------------------
module panel_ctrl_model #(
  parameter logic [7:0] BUSY_VAL = 8'h3c
) (
  input wire logic clk_sys,
  input wire logic panel_chip_select,
  input wire logic panel_write_strobe,
  input wire logic panel_read_strobe,
  input wire logic panel_register_select,
  input wire logic [7:0] panel_data_out,
  input wire logic panel_data_oe,
  output logic [7:0] panel_data_in,
  output logic [7:0] last_cmd,
  output logic [7:0] last_dat,
  output int n_wr
);
  logic [7:0] line_r = 8'h00;
  logic [7:0] cmd_r = 8'h00;
  logic [7:0] dat_r = 8'h00;
  int cnt_r = 0;
  assign last_cmd = cmd_r;
  assign last_dat = dat_r;
  assign n_wr = cnt_r;
  // released bus shows a changing pattern, never a held byte
  always @(posedge clk_sys) line_r <= panel_data_in;
  assign panel_data_in = (!panel_chip_select && !panel_read_strobe) ?
    (panel_register_select ? dat_r : BUSY_VAL) : ~line_r;
  // an undriven bus at the strobe edge stores unknown on purpose
  always @(posedge panel_write_strobe) begin
    if (!panel_chip_select) begin
      cnt_r <= cnt_r + 1;
      if (panel_register_select) begin
        dat_r <= panel_data_oe ? panel_data_out : 8'hxx;
      end else begin
        cmd_r <= panel_data_oe ? panel_data_out : 8'hxx;
      end
    end
  end
endmodule : panel_ctrl_model

/* tb_lcd_parallel_bus_bridge.sv */
`timescale 1ns/1ns
module tb_lcd_parallel_bus_bridge;
  import lcd_bridge_pkg::*;
  localparam logic [7:0] BUSY = 8'h3c;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_sel = 1'b0;
  logic reg_write = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, q;
  logic reg_ready, panel_irq, cs, wr, rd, rs, prst, bl, oe;
  logic [7:0] pin_in, pin_out, last_cmd, last_dat;
  logic [31:0] pin_m, mask_m, flag_m, capt_m, dat_m, cmd_m, v;
  int n_wr, error_cnt = 0, n_compared = 0, cyc = 0, base;
  always #10 clk_sys = ~clk_sys;
  lcd_parallel_bus_bridge dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ready(reg_ready),
    .panel_irq(panel_irq), .panel_chip_select(cs),
    .panel_write_strobe(wr), .panel_read_strobe(rd),
    .panel_register_select(rs), .panel_reset_line(prst),
    .panel_backlight(bl), .panel_data_in(pin_in),
    .panel_data_out(pin_out), .panel_data_oe(oe));
  panel_ctrl_model #(.BUSY_VAL(BUSY)) panel (.clk_sys(clk_sys),
    .panel_chip_select(cs), .panel_write_strobe(wr),
    .panel_read_strobe(rd), .panel_register_select(rs),
    .panel_data_out(pin_out), .panel_data_oe(oe),
    .panel_data_in(pin_in), .last_cmd(last_cmd),
    .last_dat(last_dat), .n_wr(n_wr));
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // request held until ready is sampled high at a rising edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(negedge clk_sys);
    reg_sel = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_wdata = d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (reg_ready !== 1'b1 && n < 40);
    chk("reg_ready", reg_ready, 1'b1);
    q = reg_rdata;
    @(negedge clk_sys);
    reg_sel = 1'b0;
  endtask : bus
  task wreg(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    case (a)
      12'h000: cmd_m = d[7:0];
      12'h004: dat_m = d[7:0];
      12'h00c: if (!d[0]) flag_m = 0;
      12'h010: mask_m = d[0];
      12'h04c: pin_m = d & 32'h7b;
      default: ;
    endcase
  endtask : wreg
  task rreg(input logic [11:0] a);
    logic [31:0] e;
    bus(1'b0, a, 32'h0);
    case (a)
      12'h008: e = capt_m;
      12'h00c: e = flag_m;
      12'h014: e = flag_m & mask_m;
      12'h04c: e = pin_m;
      default: e = 0;
    endcase
    chk("reg_rdata", q, e);
  endtask : rreg
  task pins;
    chk("pins", {bl, rd, rs, prst, 1'b0, wr, cs}, pin_m[6:0]);
    chk("panel_data_oe", oe, 1'b0);
    chk("panel_irq", panel_irq, flag_m & mask_m);
  endtask : pins
  // panel read answers zero now; the byte lands in the captured register
  task prd(input logic [11:0] a);
    int n;
    rreg(a);
    n = 0;
    do begin
      bus(1'b0, OFS_RAW_DONE_FLAG, 32'h0);
      n++;
    end while (q[0] !== 1'b1 && n < 20);
    flag_m = 1;
    capt_m = (a == 12'h000) ? BUSY : dat_m;
    rreg(OFS_CAPTURED_READ);
    rreg(OFS_RAW_DONE_FLAG);
    rreg(OFS_MASKED_STATUS);
    pins();
  endtask : prd
  initial begin
    pin_m = 32'h2b;
    {mask_m, flag_m, capt_m, dat_m, cmd_m} = '0;
    void'($urandom(32'h4dd5));
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    rreg(12'h008);
    rreg(12'h00c);
    rreg(12'h010);
    rreg(12'h014);
    rreg(12'h04c);
    rreg(12'h020);
    pins();
    $display("test 1 done");
    base = n_wr;
    wreg(OFS_COMMAND_BUSY, $urandom);
    wreg(OFS_DATA_PORT, $urandom);
    wreg(12'h020, $urandom);
    for (int n = 0; n < 60 && n_wr < base + 2; n++) @(negedge clk_sys);
    chk("last_cmd", last_cmd, cmd_m[7:0]);
    chk("last_dat", last_dat, dat_m[7:0]);
    chk("writes", n_wr - base, 2);
    rreg(OFS_RAW_DONE_FLAG);
    repeat (8) @(negedge clk_sys);
    pins();
    $display("test 2 done");
    prd(OFS_DATA_PORT);
    wreg(OFS_RAW_DONE_FLAG, 32'h1);
    rreg(OFS_RAW_DONE_FLAG);
    wreg(OFS_IRQ_MASK, 32'h1);
    rreg(OFS_MASKED_STATUS);
    pins();
    wreg(OFS_RAW_DONE_FLAG, 32'hfffffffe);
    rreg(OFS_RAW_DONE_FLAG);
    rreg(OFS_RAW_DONE_FLAG);
    pins();
    $display("test 3 done");
    prd(OFS_COMMAND_BUSY);
    wreg(OFS_CAPTURED_READ, $urandom);
    rreg(OFS_CAPTURED_READ);
    wreg(OFS_IRQ_MASK, 32'h0);
    rreg(OFS_IRQ_MASK);
    pins();
    $display("test 4 done");
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      wreg(OFS_PIN_CONTROL, v);
      rreg(OFS_PIN_CONTROL);
      pins();
    end
    $display("test 5 done");
    conclude();
  end
endmodule : tb_lcd_parallel_bus_bridge
